/* File: pulse_src.sv */
// Purpose: Behavioural command pulse source in place of the motion controller
// Assumes: step is called just after a rising edge of ref_clk
// Notes:   Pulse forms drop pin a low between pulses (b keeps the direction level in fmt 1); quadrature pins hold their phase
`timescale 1ns/1ps
`default_nettype none
module pulse_src (
    input  wire logic           ref_clk,
    input  wire logic [1:0]     fmt,
    output servo_cmd_pkg::pls_s pins
);
    logic [1:0] ph = 2'h0;
    initial pins = 2'h0;
    // One command step in the selected form
    task automatic step(input logic fwd);
        logic lvl;
        lvl = (fmt == 2'h1) & ~fwd;
        if (fmt == 2'h0) begin
            ph = fwd ? ph + 2'h1 : ph - 2'h1;
            pins <= {ph[1], ph[1] ^ ph[0]};
        end else begin
            pins <= {1'h0, lvl};
            @(posedge ref_clk);
            pins <= (fmt == 2'h1) ? {1'h1, lvl} : (fwd ? 2'h2 : 2'h1);
            @(posedge ref_clk);
            pins <= {1'h0, lvl};
        end
        repeat (servo_cmd_pkg::PULSE_PERIOD_CYC) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: servo_cmd_pkg.sv */
// Purpose: Shared constants and types of the pulse position command front end
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Reset values and field limits live here only
package servo_cmd_pkg;

    // Register byte offsets
    localparam logic [7:0] MODE_OFS   = 8'h00;
    localparam logic [7:0] SRC_OFS    = 8'h04;
    localparam logic [7:0] FMT_OFS    = 8'h08;
    localparam logic [7:0] PORT_OFS   = 8'h0c;
    localparam logic [7:0] INV_OFS    = 8'h10;
    localparam logic [7:0] PPR_OFS    = 8'h14;
    localparam logic [7:0] NUM_OFS    = 8'h18;
    localparam logic [7:0] DEN_OFS    = 8'h1c;
    localparam logic [7:0] DEVLIM_OFS = 8'h20;
    localparam logic [7:0] OPPR_OFS   = 8'h24;
    localparam logic [7:0] CTRL_OFS   = 8'h28;
    localparam logic [7:0] STAT_OFS   = 8'h2c;
    localparam logic [7:0] FLAG_OFS   = 8'h30;
    localparam logic [7:0] CNT_OFS    = 8'h34;

    // Reset values
    localparam logic [2:0]  MODE_RST   = 3'h0;
    localparam logic [1:0]  FMT_RST    = 2'h1;
    localparam logic [15:0] PPR_RST    = 16'h2710;
    localparam logic [15:0] NUM_RST    = 16'h0001;
    localparam logic [15:0] DEN_RST    = 16'h0001;
    localparam logic [15:0] DEVLIM_RST = 16'h7530;
    localparam logic [15:0] OPPR_RST   = 16'h09c4;

    // Accepted value limits
    localparam logic [31:0] MODE_MAX   = 32'h0000_0006;
    localparam logic [31:0] FMT_MAX    = 32'h0000_0003;
    localparam logic [31:0] BIT_MAX    = 32'h0000_0001;
    localparam logic [31:0] HALF_MAX   = 32'h0000_ffff;
    localparam logic [31:0] OPPR_MAX   = 32'h0000_ea60;

    // Feedback counts per motor revolution (17-bit encoder)
    localparam logic [17:0] FB_COUNTS  = 18'h20000;
    localparam int          ACC_W      = 49;

    // Control and flag bit positions
    localparam int CTRL_LOCK_BIT = 0;
    localparam int CTRL_SON_BIT  = 1;
    localparam int FLG_OK_BIT    = 0;
    localparam int FLG_BUSY_BIT  = 1;
    localparam int FLG_BAD_BIT   = 2;
    localparam int FLG_LCK_BIT   = 3;
    localparam int STAT_ST_LSB   = 9;

    // Highest command pulse rate in direction plus pulse form
    localparam int CLK_MHZ          = 100;
    localparam int PULSE_MAX_KHZ    = 500;
    localparam int PULSE_PERIOD_CYC = (CLK_MHZ * 1000) / PULSE_MAX_KHZ;

    typedef enum logic [2:0] {
        MD_POS     = 3'd0,
        MD_SPD     = 3'd1,
        MD_TRQ     = 3'd2,
        MD_SPD_TRQ = 3'd3,
        MD_POS_SPD = 3'd4,
        MD_POS_TRQ = 3'd5,
        MD_BATCH   = 3'd6
    } mode_e;

    typedef enum logic [2:0] {
        ST_NRDY = 3'b001,
        ST_RDY  = 3'b010,
        ST_ON   = 3'b100
    } run_e;

    // Command pulse pin pair
    typedef struct packed {
        logic a;
        logic b;
    } pls_s;

    // Front panel indicators
    typedef struct packed {
        logic ctrl_pwr;
        logic main_rdy;
        logic fault;
        logic base_blk;
        logic rot;
        logic cmd_act;
        logic done;
        logic ot_rev;
        logic ot_fwd;
    } lamps_s;

    // Whole state of the front end
    typedef struct packed {
        logic [2:0]        mode;
        logic              src;
        logic [1:0]        fmt;
        logic              port;
        logic              inv;
        logic [15:0]       ppr;
        logic [15:0]       num;
        logic [15:0]       den;
        logic [15:0]       devlim;
        logic [15:0]       oppr;
        logic              lock;
        logic              son;
        logic [3:0]        flg;
        logic              fault;
        run_e              st;
        pls_s              pin;
        logic [31:0]       cnt;
        logic [ACC_W-1:0]  acc;
        logic              fb_vld;
        logic [31:0]       fb_prev;
        logic [32:0]       out_acc;
        logic              enc_p;
        logic              enc_d;
        lamps_s            lamps;
        logic [31:0]       rdata;
    } state_s;

endpackage

/* File: servo_pulse_position_command.sv */
// Purpose: Pulse train position command front end with gear scaling and panel status
// Assumes: Pin inputs synchronous to ref_clk; feedback is a multi-turn 17-bit count
// Notes:   Zero wait state APB slave; parameter writes are checked before storing
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module servo_pulse_position_command (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire servo_cmd_pkg::pls_s   cmd_lo,
    input  wire servo_cmd_pkg::pls_s   cmd_hi,
    input  wire logic                  ot_fwd_in,
    input  wire logic                  ot_rev_in,
    input  wire logic                  ctrl_pwr_in,
    input  wire logic                  main_pwr_in,
    input  wire logic                  mode_alt_in,
    input  wire logic                  speed_coin_in,
    input  wire logic                  speed_cmd_in,
    input  wire logic [31:0]           fb_pos,
    output logic                       enc_pulse_out,
    output logic                       enc_dir_out,
    output servo_cmd_pkg::lamps_s      lamps_out,
    output servo_cmd_pkg::run_e        run_state_out
);

    localparam servo_cmd_pkg::state_s S_RST = '{
        default: '0,
        mode:    servo_cmd_pkg::MODE_RST,
        fmt:     servo_cmd_pkg::FMT_RST,
        ppr:     servo_cmd_pkg::PPR_RST,
        num:     servo_cmd_pkg::NUM_RST,
        den:     servo_cmd_pkg::DEN_RST,
        devlim:  servo_cmd_pkg::DEVLIM_RST,
        oppr:    servo_cmd_pkg::OPPR_RST,
        st:      servo_cmd_pkg::ST_NRDY
    };

    // Quadrature step from previous and present pin pair: {rev, fwd}
    function automatic logic [1:0] quad_step(input logic [1:0] p, input logic [1:0] c);
        case ({p, c})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
            4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b10;
            default:                            quad_step = 2'b00;
        endcase
    endfunction

    // Counts added per command unit
    function automatic logic [17:0] step_num(input logic [15:0] ppr, input logic [15:0] num);
        step_num = (ppr != 16'h0000) ? servo_cmd_pkg::FB_COUNTS : {2'b00, num};
    endfunction

    // Command units per scaled count
    function automatic logic [15:0] step_den(input logic [15:0] ppr, input logic [15:0] den);
        step_den = (ppr != 16'h0000) ? ppr : den;
    endfunction

    // Writable parameter offsets
    function automatic logic is_param(input logic [7:0] a);
        is_param = (a[1:0] == 2'b00) && (a <= servo_cmd_pkg::OPPR_OFS);
    endfunction

    // Range check of a parameter write
    function automatic logic val_ok(input logic [7:0] a, input logic [31:0] d);
        case (a)
            servo_cmd_pkg::MODE_OFS: val_ok = d <= servo_cmd_pkg::MODE_MAX;
            servo_cmd_pkg::FMT_OFS:  val_ok = d <= servo_cmd_pkg::FMT_MAX;
            servo_cmd_pkg::SRC_OFS,
            servo_cmd_pkg::PORT_OFS,
            servo_cmd_pkg::INV_OFS:  val_ok = d <= servo_cmd_pkg::BIT_MAX;
            servo_cmd_pkg::NUM_OFS,
            servo_cmd_pkg::DEN_OFS:  val_ok = (d != 32'h0) && (d <= servo_cmd_pkg::HALF_MAX);
            servo_cmd_pkg::OPPR_OFS: val_ok = d <= servo_cmd_pkg::OPPR_MAX;
            default:                 val_ok = d <= servo_cmd_pkg::HALF_MAX;
        endcase
    endfunction

    localparam int ACC_W_L = servo_cmd_pkg::ACC_W;

    servo_cmd_pkg::state_s s;
    servo_cmd_pkg::state_s n;

    servo_cmd_pkg::pls_s   pin;
    logic [1:0]            stp;
    logic                  fwd;
    logic                  rev;
    logic                  pos_on;
    logic                  gate;
    logic [17:0]           snum;
    logic [15:0]           sden;
    logic [ACC_W_L-1:0]    fbm;
    logic [ACC_W_L-1:0]    diff;
    logic [ACC_W_L-1:0]    adiff;
    logic [31:0]           dlt;
    logic [31:0]           adlt;
    logic                  mapped;
    logic                  wr;
    logic                  w_lck;
    logic                  w_busy;
    logic                  w_bad;
    logic [3:0]            fset;
    logic [3:0]            fclr;
    logic [31:0]           rd;

    // APB answers in the access cycle; read data was captured at setup
    assign pready  = 1'b1;
    assign prdata  = s.rdata;
    assign pslverr = psel & penable & (~mapped | (pwrite & (w_lck | w_busy | w_bad)));

    assign enc_pulse_out = s.enc_p;
    assign enc_dir_out   = s.enc_d;
    assign lamps_out     = s.lamps;
    assign run_state_out = s.st;

    // Next state of the whole front end
    always_comb begin
        n = s;
        // Low or high speed pin pair
        pin = s.port ? cmd_hi : cmd_lo;
        pos_on = (s.mode == servo_cmd_pkg::MD_POS)
               | ((s.mode == servo_cmd_pkg::MD_POS_SPD) & ~mode_alt_in)
               | ((s.mode == servo_cmd_pkg::MD_POS_TRQ) & ~mode_alt_in);
        stp = quad_step({s.pin.a, s.pin.b}, {pin.a, pin.b});
        case (s.fmt)
            2'd0: begin
                fwd = stp[0];
                rev = stp[1];
            end
            2'd1: begin
                // edge counting, one edge per clock is ample at 500 kHz
                fwd = pin.a & ~s.pin.a & ~pin.b;
                rev = pin.a & ~s.pin.a & pin.b;
            end
            default: begin
                // simultaneous edges cancel, nothing is counted
                fwd = (pin.a & ~s.pin.a) & ~(pin.b & ~s.pin.b);
                rev = (pin.b & ~s.pin.b) & ~(pin.a & ~s.pin.a);
            end
        endcase
        if (s.inv) begin
            {fwd, rev} = {rev, fwd};
        end
        n.pin = pin;
        gate = pos_on & ~s.src & (s.st == servo_cmd_pkg::ST_ON);
        // forward blocked and reverse blocked by overtravel
        fwd = fwd & gate & ~ot_fwd_in;
        rev = rev & gate & ~ot_rev_in;
        // source of scale, gear ratio, feedback resolution
        snum = step_num(s.ppr, s.num);
        sden = step_den(s.ppr, s.den);
        fbm = ACC_W_L'($signed(fb_pos) * $signed({1'b0, sden}));
        diff = s.acc - fbm;
        adiff = diff[ACC_W_L-1] ? -diff : diff;
        if (s.st != servo_cmd_pkg::ST_ON) begin
            // Follow feedback while idle so enabling causes no jump
            n.acc = fbm;
        end else if (fwd) begin
            n.acc = s.acc + ACC_W_L'(snum);
        end else if (rev) begin
            n.acc = s.acc - ACC_W_L'(snum);
        end
        if (fwd) begin
            n.cnt = s.cnt + 32'h1;
        end else if (rev) begin
            n.cnt = s.cnt - 32'h1;
        end
        // Deviation beyond limit latches a fault until servo is switched off
        if (!s.son) begin
            n.fault = 1'b0;
        end else if ((s.st == servo_cmd_pkg::ST_ON)
                     && (adiff > ACC_W_L'({16'h0, s.devlim} * {16'h0, sden}))) begin
            n.fault = 1'b1;
        end
        // encoder emulation; large feedback jumps drain one pulse per clock
        dlt = fb_pos - s.fb_prev;
        adlt = dlt[31] ? -dlt : dlt;
        n.fb_prev = fb_pos;
        n.fb_vld = 1'b1;
        n.enc_p = 1'b0;
        if (s.out_acc >= {15'h0, servo_cmd_pkg::FB_COUNTS}) begin
            n.out_acc = s.out_acc - {15'h0, servo_cmd_pkg::FB_COUNTS};
            n.enc_p = 1'b1;
        end
        if (s.fb_vld && (dlt != 32'h0)) begin
            n.out_acc = n.out_acc + 33'({17'h0, s.oppr} * adlt[15:0]);
            n.enc_d = dlt[31];
        end
        if (!main_pwr_in || s.fault) begin
            n.st = servo_cmd_pkg::ST_NRDY;
        end else if (s.son) begin
            n.st = servo_cmd_pkg::ST_ON;
        end else begin
            n.st = servo_cmd_pkg::ST_RDY;
        end
        // Register access decode
        mapped = (paddr[1:0] == 2'b00) && (paddr <= servo_cmd_pkg::CNT_OFS);
        wr = psel & penable & pwrite & mapped;
        w_lck = is_param(paddr) & s.lock;
        w_busy = is_param(paddr) & ~s.lock & (s.st == servo_cmd_pkg::ST_ON);
        w_bad = is_param(paddr) & ~s.lock & (s.st != servo_cmd_pkg::ST_ON) & ~val_ok(paddr, pwdata);
        fset = '0;
        fclr = '0;
        if (wr) begin
            fset[servo_cmd_pkg::FLG_LCK_BIT] = w_lck;
            fset[servo_cmd_pkg::FLG_BUSY_BIT] = w_busy;
            fset[servo_cmd_pkg::FLG_BAD_BIT] = w_bad;
            if (is_param(paddr) && !w_lck && !w_busy && !w_bad) begin
                fset[servo_cmd_pkg::FLG_OK_BIT] = 1'b1;
                case (paddr)
                    servo_cmd_pkg::MODE_OFS: n.mode = pwdata[2:0];
                    servo_cmd_pkg::SRC_OFS:  n.src = pwdata[0];
                    servo_cmd_pkg::FMT_OFS:  n.fmt = pwdata[1:0];
                    servo_cmd_pkg::PORT_OFS: n.port = pwdata[0];
                    servo_cmd_pkg::INV_OFS:  n.inv = pwdata[0];
                    servo_cmd_pkg::PPR_OFS:  n.ppr = pwdata[15:0];
                    servo_cmd_pkg::NUM_OFS:  n.num = pwdata[15:0];
                    servo_cmd_pkg::DEN_OFS:  n.den = pwdata[15:0];
                    servo_cmd_pkg::DEVLIM_OFS: n.devlim = pwdata[15:0];
                    default:                 n.oppr = pwdata[15:0];
                endcase
            end
            if (paddr == servo_cmd_pkg::CTRL_OFS) begin
                n.lock = pwdata[servo_cmd_pkg::CTRL_LOCK_BIT];
                n.son = pwdata[servo_cmd_pkg::CTRL_SON_BIT];
            end
            if (paddr == servo_cmd_pkg::FLAG_OFS) begin
                fclr = pwdata[3:0];
            end
        end
        // New events win over a clear in the same cycle
        n.flg = (s.flg & ~fclr) | fset;
        // Panel lamps: base block and fault follow the next state, done the present one
        // base block
        n.lamps.base_blk = n.st != servo_cmd_pkg::ST_ON;
        n.lamps.done = pos_on ? ((s.st == servo_cmd_pkg::ST_ON) && (adiff < ACC_W_L'(sden))) : speed_coin_in;
        n.lamps.cmd_act = pos_on ? (fwd | rev) : speed_cmd_in;
        n.lamps.rot = s.fb_vld & (dlt != 32'h0);
        n.lamps.main_rdy = main_pwr_in;
        n.lamps.ctrl_pwr = ctrl_pwr_in;
        n.lamps.ot_fwd = ot_fwd_in;
        n.lamps.ot_rev = ot_rev_in;
        n.lamps.fault = n.fault;
        // Read data captured in the setup cycle
        case (paddr)
            servo_cmd_pkg::MODE_OFS:   rd = {29'h0, s.mode};
            servo_cmd_pkg::SRC_OFS:    rd = {31'h0, s.src};
            servo_cmd_pkg::FMT_OFS:    rd = {30'h0, s.fmt};
            servo_cmd_pkg::PORT_OFS:   rd = {31'h0, s.port};
            servo_cmd_pkg::INV_OFS:    rd = {31'h0, s.inv};
            servo_cmd_pkg::PPR_OFS:    rd = {16'h0, s.ppr};
            servo_cmd_pkg::NUM_OFS:    rd = {16'h0, s.num};
            servo_cmd_pkg::DEN_OFS:    rd = {16'h0, s.den};
            servo_cmd_pkg::DEVLIM_OFS: rd = {16'h0, s.devlim};
            servo_cmd_pkg::OPPR_OFS:   rd = {16'h0, s.oppr};
            servo_cmd_pkg::CTRL_OFS:   rd = {30'h0, s.son, s.lock};
            servo_cmd_pkg::STAT_OFS:   rd = {20'h0, s.st, s.lamps};
            servo_cmd_pkg::FLAG_OFS:   rd = {28'h0, s.flg};
            servo_cmd_pkg::CNT_OFS:    rd = s.cnt;
            default:                   rd = 32'h0;
        endcase
        if (psel && !penable) begin
            n.rdata = rd;
        end
    end

    // Single state register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s <= S_RST;
        end else begin
            s <= n;
        end
    end

    property p_mode_range;
        @(posedge ref_clk) disable iff (!rst_n)
        wr && (paddr == servo_cmd_pkg::MODE_OFS) && (pwdata > servo_cmd_pkg::MODE_MAX)
        && !s.lock && (s.st != servo_cmd_pkg::ST_ON)
        |=> (s.mode == $past(s.mode)) && s.flg[servo_cmd_pkg::FLG_BAD_BIT];
    endproperty
    a_mode_range: assert property (p_mode_range) else $error("mode took a value above 6");

    property p_dir_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.fmt == 2'd1) && !s.inv && gate && !ot_fwd_in && pin.a && !s.pin.a && !pin.b
        |=> s.cnt == $past(s.cnt) + 32'h1;
    endproperty
    a_dir_pulse: assert property (p_dir_pulse) else $error("direction plus pulse edge not counted");

    property p_invert;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.fmt == 2'd1) && s.inv && gate && !ot_rev_in && pin.a && !s.pin.a && !pin.b
        |=> s.cnt == $past(s.cnt) - 32'h1;
    endproperty
    a_invert: assert property (p_invert) else $error("inverted pulse not counted reverse");

    property p_ppr_scale;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == servo_cmd_pkg::ST_ON) && (s.ppr != 16'h0) && fwd
        |=> s.acc == $past(s.acc) + ACC_W_L'(servo_cmd_pkg::FB_COUNTS);
    endproperty
    a_ppr_scale: assert property (p_ppr_scale) else $error("pulse per rev scaling wrong");

    property p_gear_scale;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.st == servo_cmd_pkg::ST_ON) && (s.ppr == 16'h0) && (fwd || rev)
        |=> s.acc == ($past(fwd) ? $past(s.acc) + ACC_W_L'($past(s.num))
                                 : $past(s.acc) - ACC_W_L'($past(s.num)));
    endproperty
    a_gear_scale: assert property (p_gear_scale) else $error("gear numerator not applied");

    property p_base_block;
        @(posedge ref_clk) disable iff (!rst_n)
        !s.son ##1 !s.son |=> s.lamps.base_blk;
    endproperty
    a_base_block: assert property (p_base_block) else $error("base block lamp dark while disabled");

    property p_ot_fwd;
        @(posedge ref_clk) disable iff (!rst_n)
        ot_fwd_in |=> ($signed(s.cnt) <= $signed($past(s.cnt))) && s.lamps.ot_fwd;
    endproperty
    a_ot_fwd: assert property (p_ot_fwd) else $error("forward command taken in overtravel");

    property p_busy;
        @(posedge ref_clk) disable iff (!rst_n)
        wr && is_param(paddr) && !s.lock && (s.st == servo_cmd_pkg::ST_ON)
        |-> pslverr ##1 (s.flg[servo_cmd_pkg::FLG_BUSY_BIT] && !$rose(s.flg[servo_cmd_pkg::FLG_OK_BIT]));
    endproperty
    a_busy: assert property (p_busy) else $error("write while enabled not refused");

    property p_locked;
        @(posedge ref_clk) disable iff (!rst_n)
        wr && is_param(paddr) && s.lock
        |-> pslverr ##1 (s.flg[servo_cmd_pkg::FLG_LCK_BIT] && (s.ppr == $past(s.ppr)));
    endproperty
    a_locked: assert property (p_locked) else $error("locked parameter was written");

endmodule

`default_nettype wire

/* File: servo_pulse_position_command_tb.sv */
// Purpose: Self-checking bench for the pulse position command front end
// Assumes: Zero wait APB slave; outputs read just after an edge, before it lands
// Notes:   Small gear figures make a fault cheap to reach
`timescale 1ns/1ps
`default_nettype none
module servo_pulse_position_command_tb;
    logic                  ref_clk = '0, rst_n = '0, psel = '0, penable = '0, pwrite = '0, err, fwd;
    logic                  mode_alt_in = '0, ot_fwd_in = '0, ot_rev_in = '0, main_pwr_in = '0, ctrl_pwr_in = '1;
    logic                  speed_coin_in = '0, speed_cmd_in = '0, pready, pslverr, enc_pulse_out, enc_dir_out;
    logic [1:0]            fmt = '0;
    logic [7:0]            paddr = '0;
    logic [31:0]           pwdata = '0, fb_pos = '0, prdata, rd, v;
    logic [31:0]           rv [10] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h2710, 32'h1, 32'h1, 32'h7530, 32'h9c4};
    logic [31:0]           mx [10] = '{32'h6, 32'h1, 32'h3, 32'h1, 32'h1, 32'hffff, 32'hffff, 32'hffff, 32'hffff, 32'hea60};
    logic [31:0]           gv [9] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h2, 32'h1, 32'h3};
    servo_cmd_pkg::pls_s   pins;
    servo_cmd_pkg::lamps_s lamps_out;
    servo_cmd_pkg::run_e   run_state_out;
    int                    n_errors = 0, n_tests = 0, n_enc = 0, want;

    servo_pulse_position_command dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmd_lo(pins), .cmd_hi(pins), .ot_fwd_in, .ot_rev_in, .ctrl_pwr_in,
        .main_pwr_in, .mode_alt_in, .speed_coin_in, .speed_cmd_in, .fb_pos, .enc_pulse_out, .enc_dir_out,
        .lamps_out, .run_state_out);
    pulse_src src (.ref_clk, .fmt, .pins);

    initial forever #5 ref_clk = ~ref_clk;
    // Encoder pulses counted as they come
    always @(posedge ref_clk) if (enc_pulse_out === 1'h1) n_enc <= n_enc + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        bus(1'h1, a, d);
        chk(32'(err), 32'(e));
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    // Count change expected for one step; overtravel judged after inversion
    function automatic int delta(input logic f, input logic inv, input logic otf, input logic otr);
        return (f ^ inv) ? (otf ? 0 : 1) : (otr ? 0 : -1);
    endfunction
    task automatic report_and_stop();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard, well above the expected run of under ten thousand cycles
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        void'($urandom(79304));
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk(32'(run_state_out), 32'(servo_cmd_pkg::ST_NRDY));
        chk(32'({lamps_out.ctrl_pwr, lamps_out.main_rdy, lamps_out.base_blk}), 32'h5);
        for (int i = 0; i < 10; i++) rchk(8'(4 * i), rv[i]);
        // Legal random values stick; one past the limit changes nothing
        for (int i = 0; i < 10; i++) begin
            v = $urandom_range(mx[i], (i == 6 || i == 7) ? 1 : 0);
            wr(8'(4 * i), v, 1'h0);
            wr(8'(4 * i), mx[i] + 32'h1, 1'h1);
            rchk(8'(4 * i), v);
        end
        wr(servo_cmd_pkg::NUM_OFS, 32'h0, 1'h1);
        rchk(servo_cmd_pkg::FLAG_OFS, 32'h5);
        rchk(8'h38, 32'h0);
        chk(32'(err), 32'h1);
        main_pwr_in <= 1'h1;
        wr(servo_cmd_pkg::CTRL_OFS, 32'h1, 1'h0);
        wr(servo_cmd_pkg::MODE_OFS, 32'h0, 1'h1);
        chk(32'(run_state_out), 32'(servo_cmd_pkg::ST_RDY));
        wr(servo_cmd_pkg::CTRL_OFS, 32'h2, 1'h0);
        wr(servo_cmd_pkg::MODE_OFS, 32'h0, 1'h1);
        bus(1'h0, servo_cmd_pkg::FLAG_OFS, 32'h0);
        chk(rd & 32'ha, 32'ha);
        chk(32'({run_state_out, lamps_out.main_rdy, lamps_out.base_blk}), 32'h12);
        // Non-position half of a mixed mode shows the speed loop levels
        wr(servo_cmd_pkg::CTRL_OFS, 32'h0, 1'h0);
        wr(servo_cmd_pkg::MODE_OFS, 32'h4, 1'h0);
        mode_alt_in <= 1'h1;
        speed_coin_in <= 1'h1;
        speed_cmd_in <= 1'h1;
        ctrl_pwr_in <= 1'h0;
        repeat (3) @(posedge ref_clk);
        chk(32'({lamps_out.done, lamps_out.cmd_act, lamps_out.ctrl_pwr}), 32'h6);
        mode_alt_in <= 1'h0;
        ctrl_pwr_in <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk(32'({lamps_out.done, lamps_out.cmd_act, lamps_out.ctrl_pwr}), 32'h1);
        // One motor turn forward gives exactly the set number of output pulses
        wr(servo_cmd_pkg::OPPR_OFS, 32'h4, 1'h0);
        want = n_enc;
        repeat (32) begin
            fb_pos <= fb_pos + 32'h1000;
            @(posedge ref_clk);
        end
        chk(32'(lamps_out.rot), 32'h1);
        repeat (40) @(posedge ref_clk);
        chk(32'(n_enc - want), 32'h4);
        chk(32'(enc_dir_out), 32'h0);
        // Gear 2/1 with a deviation limit of 3: the second pulse trips a fault
        for (int i = 0; i < 9; i++) wr(8'(4 * i), gv[i], 1'h0);
        fmt <= 2'h1;
        wr(servo_cmd_pkg::CTRL_OFS, 32'h2, 1'h0);
        // Run state and then the done lamp each take one more clock
        repeat (2) @(posedge ref_clk);
        chk(32'(lamps_out.done), 32'h1);
        src.step(1'h1);
        chk(32'(run_state_out), 32'(servo_cmd_pkg::ST_ON));
        src.step(1'h1);
        chk(32'({run_state_out, lamps_out.fault}), 32'h3);
        wr(servo_cmd_pkg::CTRL_OFS, 32'h0, 1'h0);
        // Fault clears first, the run state follows a clock later
        repeat (2) @(posedge ref_clk);
        chk(32'(run_state_out), 32'(servo_cmd_pkg::ST_RDY));
        wr(servo_cmd_pkg::PPR_OFS, 32'h2710, 1'h0);
        wr(servo_cmd_pkg::DEVLIM_OFS, 32'hffff, 1'h0);
        // Every format with and without inversion, random directions and overtravel
        for (int f = 0; f < 8; f++) begin
            fmt <= 2'(f / 2);
            wr(servo_cmd_pkg::FMT_OFS, 32'(f / 2), 1'h0);
            wr(servo_cmd_pkg::INV_OFS, 32'(f % 2), 1'h0);
            wr(servo_cmd_pkg::CTRL_OFS, 32'h2, 1'h0);
            bus(1'h0, servo_cmd_pkg::CNT_OFS, 32'h0);
            want = int'(rd);
            repeat (4) begin
                fwd = 1'($urandom);
                ot_fwd_in <= ($urandom_range(3) == 0);
                ot_rev_in <= ($urandom_range(3) == 0);
                @(posedge ref_clk);
                want += delta(fwd, 1'(f % 2), ot_fwd_in, ot_rev_in);
                src.step(fwd);
                chk(32'({lamps_out.ot_rev, lamps_out.ot_fwd}), 32'({ot_rev_in, ot_fwd_in}));
            end
            rchk(servo_cmd_pkg::CNT_OFS, 32'(want));
            wr(servo_cmd_pkg::CTRL_OFS, 32'h0, 1'h0);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
